// file: pkg/usart_regs.svh
/*
  register indices, field positions, reset values and frame lengths of the
  synchronous slave serial port.
  assumes: included by bare name; definitions only.
*/
`ifndef USART_REGS_SVH
`define USART_REGS_SVH

// register indices (byte address is four times the index)
`define IDX_PERIPHERAL_IRQ_FLAGS    8'h0C
`define IDX_RECEIVE_STATUS_CONTROL  8'h18
`define IDX_TRANSMIT_HOLDING        8'h19
`define IDX_RECEIVE_FIFO_DATA       8'h1A
`define IDX_PERIPHERAL_IRQ_ENABLES  8'h8C
`define IDX_TRANSMIT_STATUS_CONTROL 8'h98
`define IDX_BAUD_DIVISOR            8'h99

// peripheral flag and enable bit positions
`define PIR_RX_READY   5
`define PIR_TX_READY   4
`define PIR_RESERVED   6
`define PIR_STORE_MASK 8'h8F  // flag bits kept as plain storage

// transmit status and control bit positions
`define TXS_CLOCK_SRC  7
`define TXS_NINE_BIT   6
`define TXS_TX_ENABLE  5
`define TXS_SYNC_MODE  4
`define TXS_HIGH_BAUD  2
`define TXS_SHIFT_IDLE 1
`define TXS_NINTH_BIT  0

// receive status and control bit positions
`define RCS_PORT_EN    7
`define RCS_NINE_BIT   6
`define RCS_SINGLE_RX  5
`define RCS_CONT_RX    4
`define RCS_FRAMING    2
`define RCS_OVERRUN    1
`define RCS_NINTH_BIT  0

// reset values
`define RST_BYTE       8'h00
`define RST_TRANSMIT_STATUS_CONTROL      8'h02
`define LINK_IDLE      2'h3   // both link pins idle high

// frame lengths and fifo depth
`define FRAME_8        4'h8
`define FRAME_9        4'h9
`define FIFO_DEPTH     2'h2

`endif

// file: pkg/usart_pkg.sv
/*
  types shared by the synchronous slave serial port.
  assumes: nothing is imported; users write usart_pkg::name.
*/
`default_nettype none
package usart_pkg;
  // transmit control fields held by the register file
  typedef struct packed {
    logic clock_source_select;
    logic tx_nine_bit_enable;
    logic tx_enable;
    logic sync_mode_select;
    logic high_baud_select;
    logic tx_ninth_bit;
  } tx_ctrl_t;
  // receive control fields held by the register file
  typedef struct packed {
    logic serial_port_enable;
    logic rx_nine_bit_enable;
    logic single_rx_enable;
    logic continuous_rx_enable;
  } rx_ctrl_t;
  // one received word as it sits in the fifo
  typedef struct packed {
    logic       rx_ninth_bit;
    logic [7:0] data;
  } rx_word_t;
  // transmit shifter state
  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;
endpackage
`default_nettype wire

// file: rtl/link_sync.sv
/*
  three-stage synchroniser for link pins with agreement filter and
  falling edge pulse.
  assumes: inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "usart_regs.svh"
module link_sync
(
  // system
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // raw pins
  input  wire logic [1:0] pin_i,
  // filtered levels and falling edges
  output logic      [1:0] level_o,
  output logic      [1:0] fall_o
);
  logic [1:0] s1_reg;   // metastable stage, read by s2 only
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;

  // three flops in a row
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= `LINK_IDLE;
      s2_reg <= `LINK_IDLE;
      s3_reg <= `LINK_IDLE;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      level_o <= `LINK_IDLE;
      fall_o  <= 2'h0;
    end
    else
    begin
      level_o <= (s2_reg & s3_reg) | (level_o & (s2_reg ^ s3_reg));
      fall_o  <= level_o & ~s2_reg & ~s3_reg;
    end
  end
endmodule // link_sync
`default_nettype wire

// file: rtl/rx_fifo_mem.sv
/*
  two-word storage of the receive fifo, registered read data.
  assumes: pointers are kept by the instantiating module.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_mem
(
  // system
  input  wire logic                clk_i,
  // write port
  input  wire logic                wr_en_i,
  input  wire logic                wr_addr_i,
  input  wire usart_pkg::rx_word_t wr_data_i,
  // read port
  input  wire logic                rd_addr_i,
  output usart_pkg::rx_word_t      rd_data_o
);
  usart_pkg::rx_word_t mem [2];   // two entries

  // write and registered read; read sees old data on a collision
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // rx_fifo_mem
`default_nettype wire

// file: rtl/usart_sync_slave.sv
/*
  synchronous slave serial port: wishbone register file, transmit holding
  and shift path, receive shift path into a two-word fifo, sleep wake.
  assumes: clk_i 10 MHz, rst_i synchronous active high; an outside master
  drives the shift clock and samples data on its falling edge.
*/
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "usart_regs.svh"

module usart_sync_slave
(
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // processor sleep and wake
  input  wire logic        sleep_i,
  output logic             wake_o,
  // link pins
  input  wire logic        shift_clock_pin_i,
  input  wire logic        serial_data_pin_i,
  output logic             serial_data_pin_o,
  output logic             serial_data_pin_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  // register file
  usart_pkg::tx_ctrl_t  tx_ctrl_reg;        // transmit control fields
  usart_pkg::rx_ctrl_t  rx_ctrl_reg;        // receive control fields
  logic [7:0]           irq_enable_reg;     // peripheral enables
  logic [7:0]           irq_misc_reg;       // neighbours' flag bits
  logic [7:0]           baud_divisor_reg;   // unused in slave mode
  // transmit path
  logic [7:0]           hold_reg;           // transmit holding word
  logic                 hold_full_reg;      // holding word waiting
  logic [8:0]           tsr_reg;            // transmit shifter
  logic [3:0]           tx_cnt_reg;         // bits still to send
  usart_pkg::tx_state_t tx_state_reg;
  // receive path
  logic [8:0]           rsr_reg;            // receive shifter
  logic [3:0]           rx_cnt_reg;         // bits taken so far
  logic                 overrun_reg;        // overrun error
  logic [1:0]           fifo_cnt_reg;       // words in fifo
  logic                 wr_ptr_reg;
  logic                 rd_ptr_reg;
  usart_pkg::rx_word_t  fifo_head;          // head word of fifo
  usart_pkg::rx_word_t  rx_word;            // word just completed
  // link
  logic [1:0]           link_level;         // [0] clock, [1] data
  logic [1:0]           link_fall;
  // decoded terms
  logic                 req;
  logic                 wr_lo;
  logic                 rd_req;
  logic                 mode_ok;
  logic                 tx_load;
  logic                 tx_last;
  logic                 rx_active;
  logic                 rx_done;
  logic                 push;
  logic                 pop;
  logic                 ovr_set;
  logic                 tx_ready_flag;
  logic                 rx_ready_flag;
  logic [3:0]           tx_frame;
  logic [3:0]           rx_frame;
  logic [8:0]           rx_shift;
  logic [7:0]           rd_byte;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // address hit against a register index
  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    hit = (adr[9:2] == idx);
  endfunction

  // frame length from the nine-bit select
  function automatic logic [3:0] frame_len(input logic nine);
    frame_len = nine ? `FRAME_9 : `FRAME_8;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link synchroniser: clock pin is only ever an input here

  link_sync u_link_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({serial_data_pin_i, shift_clock_pin_i}),
    .level_o (link_level),
    .fall_o  (link_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode

  // one request per handshake, answered the cycle after it appears
  assign req    = cyc_i & stb_i & ~ack_o;
  assign wr_lo  = req & we_i & sel_i[0];
  assign rd_req = req & ~we_i;

  // slave synchronous mode select
  assign mode_ok = rx_ctrl_reg.serial_port_enable
                 & tx_ctrl_reg.sync_mode_select
                 & ~tx_ctrl_reg.clock_source_select;

  assign tx_frame = frame_len(tx_ctrl_reg.tx_nine_bit_enable);
  assign rx_frame = frame_len(rx_ctrl_reg.rx_nine_bit_enable);

  // holding word enters an idle shifter at once, also in sleep
  assign tx_load = mode_ok & tx_ctrl_reg.tx_enable
                 & hold_full_reg & (tx_state_reg == usart_pkg::TX_IDLE);
  assign tx_last = (tx_state_reg == usart_pkg::TX_SHIFT)
                 & link_fall[0] & (tx_cnt_reg == 4'h1);

  // single receive enable deliberately not looked at
  assign rx_active = mode_ok & rx_ctrl_reg.continuous_rx_enable
                   & (tx_state_reg == usart_pkg::TX_IDLE);
  assign rx_shift  = {link_level[1], rsr_reg[8:1]};
  assign rx_done   = rx_active & link_fall[0]
                   & (rx_cnt_reg == rx_frame - 4'h1);

  // word placement: nine-bit words keep the top bit apart
  assign rx_word.rx_ninth_bit = rx_ctrl_reg.rx_nine_bit_enable
                              & rx_shift[8];
  assign rx_word.data = rx_ctrl_reg.rx_nine_bit_enable ? rx_shift[7:0]
                                                       : rx_shift[8:1];

  // fifo traffic; an overrun blocks every later push, reads still drain the fifo
  assign push    = rx_done & ~overrun_reg & (fifo_cnt_reg != `FIFO_DEPTH);
  assign ovr_set = rx_done & ~overrun_reg & (fifo_cnt_reg == `FIFO_DEPTH);
  assign pop     = rd_req & hit(adr_i, `IDX_RECEIVE_FIFO_DATA)
                 & (fifo_cnt_reg != 2'h0);

  // ready flags are hardware state, not storage
  assign tx_ready_flag = ~hold_full_reg;
  assign rx_ready_flag = (fifo_cnt_reg != 2'h0);

  ////////////////////////////////////////////////////////////////////////
  // register file writes

  // transmit control; the shifter-idle bit is read-only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_ctrl_reg <= '0;
    end
    else if (wr_lo && hit(adr_i, `IDX_TRANSMIT_STATUS_CONTROL))
    begin
      tx_ctrl_reg.clock_source_select <= dat_i[`TXS_CLOCK_SRC];
      tx_ctrl_reg.tx_nine_bit_enable  <= dat_i[`TXS_NINE_BIT];
      tx_ctrl_reg.tx_enable           <= dat_i[`TXS_TX_ENABLE];
      tx_ctrl_reg.sync_mode_select    <= dat_i[`TXS_SYNC_MODE];
      tx_ctrl_reg.high_baud_select    <= dat_i[`TXS_HIGH_BAUD];
      tx_ctrl_reg.tx_ninth_bit        <= dat_i[`TXS_NINTH_BIT];
    end
  end

  // receive control; error and ninth-bit fields are read-only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_ctrl_reg <= '0;
    end
    else if (wr_lo && hit(adr_i, `IDX_RECEIVE_STATUS_CONTROL))
    begin
      rx_ctrl_reg.serial_port_enable   <= dat_i[`RCS_PORT_EN];
      rx_ctrl_reg.rx_nine_bit_enable   <= dat_i[`RCS_NINE_BIT];
      rx_ctrl_reg.single_rx_enable     <= dat_i[`RCS_SINGLE_RX];
      rx_ctrl_reg.continuous_rx_enable <= dat_i[`RCS_CONT_RX];
    end
  end

  // plain storage registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_enable_reg   <= `RST_BYTE;
      irq_misc_reg     <= `RST_BYTE;
      baud_divisor_reg <= `RST_BYTE;
    end
    else if (wr_lo)
    begin
      if (hit(adr_i, `IDX_PERIPHERAL_IRQ_ENABLES))
      begin
        irq_enable_reg <= dat_i[7:0];
      end
      // the port's own flags and the reserved bit are not stored
      if (hit(adr_i, `IDX_PERIPHERAL_IRQ_FLAGS))
      begin
        irq_misc_reg <= dat_i[7:0] & `PIR_STORE_MASK;
      end
      if (hit(adr_i, `IDX_BAUD_DIVISOR))
      begin
        baud_divisor_reg <= dat_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit path

  // holding register: a new write wins over a same-cycle transfer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_reg      <= `RST_BYTE;
      hold_full_reg <= 1'b0;
    end
    else if (wr_lo && hit(adr_i, `IDX_TRANSMIT_HOLDING))
    begin
      hold_reg      <= dat_i[7:0];
      hold_full_reg <= 1'b1;
    end
    else if (tx_load)
    begin
      hold_full_reg <= 1'b0;
    end
  end

  // shifter: lsb first, advanced on each falling shift clock edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_state_reg <= usart_pkg::TX_IDLE;
      tsr_reg      <= 9'h000;
      tx_cnt_reg   <= 4'h0;
    end
    else
    begin
      case (tx_state_reg)
        usart_pkg::TX_IDLE:
        begin
          if (tx_load)
          begin
            // stored ninth bit rides on top in nine-bit mode
            tsr_reg      <= {tx_ctrl_reg.tx_ninth_bit, hold_reg};
            tx_cnt_reg   <= tx_frame;
            tx_state_reg <= usart_pkg::TX_SHIFT;
          end
        end
        usart_pkg::TX_SHIFT:
        begin
          // dropping the enable or the mode aborts the word
          if (!mode_ok || !tx_ctrl_reg.tx_enable)
          begin
            tx_state_reg <= usart_pkg::TX_IDLE;
          end
          else if (tx_last)
          begin
            tx_state_reg <= usart_pkg::TX_IDLE;
          end
          else if (link_fall[0])
          begin
            tsr_reg    <= {1'b0, tsr_reg[8:1]};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
          end
        end
        default:
        begin
          tx_state_reg <= usart_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // data pin: first bit shows at load, next bit after each falling edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_data_pin_o      <= 1'b1;
      serial_data_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      if (tx_load)
      begin
        serial_data_pin_o <= hold_reg[0];
      end
      else if (tx_state_reg == usart_pkg::TX_SHIFT && link_fall[0])
      begin
        serial_data_pin_o <= tsr_reg[1];
      end
      // drive only while set up to transmit and not receiving
      serial_data_pin_oe_n_o <= ~(mode_ok & tx_ctrl_reg.tx_enable
                                  & ~rx_ctrl_reg.continuous_rx_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive path

  // shifter and bit count; the count clears whenever reception is off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rsr_reg    <= 9'h000;
      rx_cnt_reg <= 4'h0;
    end
    else if (!rx_active)
    begin
      rx_cnt_reg <= 4'h0;
    end
    else if (rx_done)
    begin
      rx_cnt_reg <= 4'h0;
    end
    else if (link_fall[0])
    begin
      rsr_reg    <= rx_shift;
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
    end
  end

  // overrun: only clearing the continuous enable removes it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      overrun_reg <= 1'b0;
    end
    else if (!rx_ctrl_reg.continuous_rx_enable)
    begin
      overrun_reg <= 1'b0;
    end
    else if (ovr_set)
    begin
      overrun_reg <= 1'b1;
    end
  end

  // fifo pointers and fill; push and pop may share a cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fifo_cnt_reg <= 2'h0;
      wr_ptr_reg   <= 1'b0;
      rd_ptr_reg   <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop)
      begin
        fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
      end
      else if (pop && !push)
      begin
        fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
      end
    end
  end

  // storage for the two words
  rx_fifo_mem u_rx_fifo_mem
  (
    .clk_i     (clk_i),
    .wr_en_i   (push),
    .wr_addr_i (wr_ptr_reg),
    .wr_data_i (rx_word),
    .rd_addr_i (rd_ptr_reg),
    .rd_data_o (fifo_head)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux and bus answer

  // reserved and unmapped bits read as zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit(adr_i, `IDX_PERIPHERAL_IRQ_FLAGS))
    begin
      rd_byte = irq_misc_reg;
      rd_byte[`PIR_RX_READY] = rx_ready_flag;
      rd_byte[`PIR_TX_READY] = tx_ready_flag;
    end
    else if (hit(adr_i, `IDX_RECEIVE_STATUS_CONTROL))
    begin
      rd_byte[`RCS_PORT_EN]   = rx_ctrl_reg.serial_port_enable;
      rd_byte[`RCS_NINE_BIT]  = rx_ctrl_reg.rx_nine_bit_enable;
      rd_byte[`RCS_SINGLE_RX] = rx_ctrl_reg.single_rx_enable;
      rd_byte[`RCS_CONT_RX]   = rx_ctrl_reg.continuous_rx_enable;
      rd_byte[`RCS_OVERRUN]   = overrun_reg;
      // ninth bit belongs to the head word, so read it first
      rd_byte[`RCS_NINTH_BIT] = rx_ready_flag & fifo_head.rx_ninth_bit;
    end
    else if (hit(adr_i, `IDX_RECEIVE_FIFO_DATA))
    begin
      rd_byte = rx_ready_flag ? fifo_head.data : 8'h00;
    end
    else if (hit(adr_i, `IDX_PERIPHERAL_IRQ_ENABLES))
    begin
      rd_byte = irq_enable_reg;
    end
    else if (hit(adr_i, `IDX_TRANSMIT_STATUS_CONTROL))
    begin
      rd_byte[`TXS_CLOCK_SRC]  = tx_ctrl_reg.clock_source_select;
      rd_byte[`TXS_NINE_BIT]   = tx_ctrl_reg.tx_nine_bit_enable;
      rd_byte[`TXS_TX_ENABLE]  = tx_ctrl_reg.tx_enable;
      rd_byte[`TXS_SYNC_MODE]  = tx_ctrl_reg.sync_mode_select;
      rd_byte[`TXS_HIGH_BAUD]  = tx_ctrl_reg.high_baud_select;
      rd_byte[`TXS_SHIFT_IDLE] = (tx_state_reg == usart_pkg::TX_IDLE);
      rd_byte[`TXS_NINTH_BIT]  = tx_ctrl_reg.tx_ninth_bit;
    end
    else if (hit(adr_i, `IDX_BAUD_DIVISOR))
    begin
      rd_byte = baud_divisor_reg;
    end
  end

  // every address is answered, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      if (rd_req)
      begin
        dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sleep wake: enabled ready flags raise a wake request

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_o <= 1'b0;
    end
    else
    begin
      wake_o <= sleep_i
              & ((tx_ready_flag & irq_enable_reg[`PIR_TX_READY])
               | (rx_ready_flag & irq_enable_reg[`PIR_RX_READY]));
    end
  end

endmodule // usart_sync_slave
`default_nettype wire

// file: tb/usart_props.sv
/*
  bus, reset and wake checks on the serial port ports.
  assumes: bound to usart_sync_slave; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module usart_props
(
  // system
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [9:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // sleep and link
  input wire logic        sleep_i,
  input wire logic        wake_o,
  input wire logic        serial_data_pin_o,
  input wire logic        serial_data_pin_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  ack_timely_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (ack_o && !we_i && adr_i[9:2] == 8'h00
    |-> dat_o == 32'h00000000) else $error("unmapped read not zero");
  flag_resv_a: assert property (ack_o && !we_i && adr_i[9:2] == 8'h0C
    |-> !dat_o[6]) else $error("reserved flag bit set");
  wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
    else $error("wake outside sleep");
  rst_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !wake_o
    && serial_data_pin_o && serial_data_pin_oe_n_o) else $error("reset state");
endmodule // usart_props
bind usart_sync_slave usart_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .dat_o, .ack_o, .sleep_i, .wake_o, .serial_data_pin_o,
  .serial_data_pin_oe_n_o);
`default_nettype wire

// file: tb/link_master.sv
/*
  outside master of the link: makes the shift clock and data.
  assumes: the bench resolves the data line and feeds it to line_i.
*/
`timescale 1ns/1ps
`default_nettype none
module link_master
(
  // line level seen by both parties
  input  wire logic line_i,
  // shift clock and data drive
  output logic      ck_o,
  output logic      dt_o
);
  logic drv;  // data driven inside a frame
  logic d;    // bit under way
  initial
  begin
    ck_o = 1'b1; // clock stands high between frames
    drv = 1'b0;
    d = 1'b0;
  end
  // released line shows the inverse, never the last value
  assign dt_o = drv ? d : ~d;
  // lsb first; data changes on rise, both sides sample on fall
  task automatic frame(input int n, input logic [8:0] tx, output logic [8:0] rx);
    rx = 9'h000;
    // edges sit 20 ns off the system clock; the return stays edge aligned
    #20 drv = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      d = tx[i];
      #400 ck_o = 1'b0;
      rx[i] = line_i;
      #400 ck_o = 1'b1;
    end
    drv = 1'b0;
    #380;
  endtask
endmodule // link_master
`default_nettype wire

// file: tb/testbench.sv
/*
  self-checking bench of the slave serial port, random words, fixed seed.
  assumes: link_master drives the link; usart_props bound to the dut.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sleep = 0;
  logic [9:0] adr = 0;
  logic [31:0] wdat = 0, dat_o;
  logic ack_o, wake_o, pin_o, oe_n, ck, m_dt, line;
  logic [7:0] v, w0, w1;
  logic [8:0] rx;
  logic [7:0] rw [3];
  int n_mismatch = 0, compares = 0, seed = 32'h76f9;
  assign line = oe_n ? m_dt : pin_o; // device drives when oe_n low
  usart_sync_slave dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o, .ack_o, .sleep_i(sleep),
    .wake_o, .shift_clock_pin_i(ck), .serial_data_pin_i(line),
    .serial_data_pin_o(pin_o), .serial_data_pin_oe_n_o(oe_n));
  link_master lm (.line_i(line), .ck_o(ck), .dt_o(m_dt));
  initial forever #50 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // expected word on the line: ninth bit only in nine-bit mode
  function automatic logic [8:0] exp_word(input logic nine, input logic b8,
    input logic [7:0] d);
    exp_word = {nine & b8, d};
  endfunction
  // classic single cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge clk_i);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, wd};
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack_o !== 1'b1 && k < 50);
    v = dat_o[7:0];
    {cyc, stb} <= 2'b00;
    if (ack_o !== 1'b1)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic wait_wake;
    for (int k = 0; k < 30 && wake_o !== 1'b1; k++)
      @(posedge clk_i);
    if (wake_o !== 1'b1)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place last
    foreach (rw[i]) rw[i] = 8'h00;
    bus(0, 8'h0C, 0); chk("flags", v, 9'h010);
    bus(0, 8'h98, 0); chk("transmit_status_control", v, 9'h002);
    bus(0, 8'h00, 0); chk("unmapped", v, 9'h000);
    $display("reset test done");
    // two words, then sleep: first sends, second waits
    w0 = 8'($random(seed));
    w1 = 8'($random(seed));
    bus(1, 8'h8C, 8'h10);
    bus(1, 8'h98, 8'h30);
    bus(1, 8'h18, 8'h80);
    bus(1, 8'h19, w0);
    bus(1, 8'h19, w1);
    bus(0, 8'h0C, 0); chk("tx ready held", v[4], 9'h000);
    sleep <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("tx no wake", wake_o, 9'h000);
    lm.frame(8, 9'h000, rx); chk("tx word 0", rx, exp_word(1'b0, 1'b0, w0));
    wait_wake(); chk("tx wake", wake_o, 9'h001);
    lm.frame(8, 9'h000, rx); chk("tx word 1", rx, {1'b0, w1});
    sleep <= 1'b0;
    bus(1, 8'h98, 8'h71);
    bus(1, 8'h19, w0);
    lm.frame(9, 9'h000, rx); chk("tx nine", rx, exp_word(1'b1, 1'b1, w0));
    $display("transmit test done");
    // single receive enable alone receives nothing
    bus(1, 8'h98, 8'h10);
    bus(1, 8'h18, 8'hA0);
    lm.frame(8, 9'h05A, rx);
    bus(0, 8'h0C, 0); chk("single_rx_enable only", v[5], 9'h000);
    bus(1, 8'h18, 8'h90);
    foreach (rw[i])
    begin
      rw[i] = 8'($random(seed));
      lm.frame(8, {1'b0, rw[i]}, rx);
    end
    bus(0, 8'h0C, 0); chk("rx ready", v[5], 9'h001);
    for (int i = 0; i < 2; i++)
    begin
      bus(0, 8'h18, 0); chk("overrun", v[1], 9'h001);
      bus(0, 8'h1A, 0); chk("rx data", v, {1'b0, rw[i]});
    end
    bus(0, 8'h0C, 0); chk("rx empty", v[5], 9'h000);
    bus(1, 8'h18, 8'h80);
    bus(0, 8'h18, 0); chk("overrun clear", v[1], 9'h000);
    // nine-bit word received in sleep wakes the processor
    bus(1, 8'h8C, 8'h20);
    bus(1, 8'h18, 8'hD0);
    sleep <= 1'b1;
    lm.frame(9, {1'b1, w1}, rx);
    wait_wake(); chk("rx wake", wake_o, 9'h001);
    sleep <= 1'b0;
    bus(0, 8'h18, 0); chk("rx ninth", v[0], 9'h001);
    bus(0, 8'h1A, 0); chk("rx nine data", v, {1'b0, w1});
    $display("receive test done");
    // clock source set: no slave transmit
    bus(1, 8'h18, 8'h80);
    bus(1, 8'hB0 ^ 8'h28, 8'hB0);
    bus(1, 8'h98, 8'hB0);
    bus(1, 8'h19, w1);
    chk("mode gate", oe_n, 9'h001);
    $display("mode test done");
    wrap_up();
  end
  initial
  begin
    #3000000;
    n_mismatch++;
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
